// File: hw/lpc_pkg.sv
// Shared constants and types for the low-power pin state controller.
// Assumes a 32-bit APB master and a power controller on the same clock.
package lpc_pkg;

	localparam int NPIN = 16;
	localparam int FN_W = 4;
	localparam int PINS_PER_REG = 8;

	// Register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_FUNC0 = 12'h004;
	localparam logic [11:0] ADDR_FUNC1 = 12'h008;
	localparam logic [11:0] ADDR_PORT = 12'h00c;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_PADIN = 12'h014;

	// Field positions
	localparam int CTRL_SPL_BIT = 0;
	localparam int CTRL_RELEASE_BIT = 1;
	localparam int PORT_DIR_LSB = 16;
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_RETURN_BIT = 4;
	localparam int STAT_MAIN_OSC_BIT = 8;
	localparam int STAT_SUB_OSC_BIT = 9;

	// Reset values
	localparam logic CTRL_SPL_RST = 1'b0;
	localparam logic [NPIN*FN_W-1:0] FUNC_RST = 64'h0;
	localparam logic [NPIN-1:0] PORT_DATA_RST = 16'h0;
	localparam logic [NPIN-1:0] PORT_DIR_RST = 16'h0;

	typedef enum logic [3:0] {
		FN_GPIO, FN_RES, FN_ANALOG, FN_JTAG, FN_TRACE,
		FN_EXTINT, FN_DEEP_STANDBY_WAKEUP_IN, FN_NMI, FN_CEC
	} lpc_func_t;

	typedef enum logic [3:0] {
		MD_RUN, MD_SLEEP, MD_MAIN_TIMER, MD_SUB_TIMER, MD_LCR_TIMER,
		MD_RTC, MD_STOP, MD_DS_RTC, MD_DS_STOP, MD_DS_RETURN
	} lpc_mode_t;

	typedef enum logic [2:0] {
		PH_POR, PH_EXTRST, PH_INTRST, PH_RUN, PH_STBY, PH_DEEP, PH_RETURN
	} lpc_phase_t;

	typedef enum logic [1:0] {ACT_HIZ, ACT_LIVE, ACT_KEEP, ACT_PORT} lpc_act_t;

	typedef struct packed {
		lpc_act_t act;
		logic in_en;
		logic pull;
		logic analog;
		logic wakeup;
	} lpc_pin_t;

	typedef struct packed {
		logic [NPIN-1:0] out;
		logic [NPIN-1:0] oe_n;
		logic [NPIN-1:0] pull;
		logic [NPIN-1:0] in_en;
		logic [NPIN-1:0] analog;
		logic [NPIN-1:0] wakeup;
	} lpc_pads_t;

endpackage : lpc_pkg

// File: hw/lpc_pin_state.sv
// Low-power pin state controller: per-pin drive, pull, input gating and
// analog/wakeup enables across reset, run, standby and deep standby.
// Assumes APB on clk_sys_i; mode_i and int_reset_i come from logic on the
// same clock, por_i and external_reset_n_i arrive asynchronously.
`timescale 1ns/1ps
module lpc_pin_state
	import lpc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Power and reset state
	input wire logic por_i,
	input wire logic external_reset_n_i,
	input wire logic int_reset_i,
	input wire lpc_mode_t mode_i,
	// Peripheral side
	input wire logic [NPIN-1:0] periph_out_i,
	input wire logic [NPIN-1:0] periph_oe_i,
	output logic [NPIN-1:0] pad_in_o,
	// Pads
	input wire logic [NPIN-1:0] pad_i,
	output lpc_pads_t pads_o,
	// Oscillators
	output logic main_osc_run_o,
	output logic sub_osc_run_o
);

	// Synchronisers for asynchronous levels
	logic [1:0] por_sync;
	logic [1:0] xrst_sync;
	logic [NPIN-1:0] pad_s1;
	logic [NPIN-1:0] pad_s2;

	// Registers
	logic standby_pin_level;
	logic [NPIN*FN_W-1:0] func;
	logic [NPIN-1:0] port_data;
	logic [NPIN-1:0] port_dir;
	logic [NPIN-1:0] held_data;
	logic [NPIN-1:0] held_dir;
	logic ret_flag;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	lpc_pads_t pads;
	logic [NPIN-1:0] pad_in;
	logic main_run;
	logic sub_run;

	logic next_spl;
	logic [NPIN*FN_W-1:0] next_func;
	logic [NPIN-1:0] next_port_data;
	logic [NPIN-1:0] next_port_dir;
	logic [NPIN-1:0] next_held_data;
	logic [NPIN-1:0] next_held_dir;
	logic next_ret_flag;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	lpc_pads_t next_pads;
	logic [NPIN-1:0] next_pad_in;
	logic next_main_run;
	logic next_sub_run;

	lpc_phase_t phase;
	logic wr_en;
	logic rd_en;

	// Pin behaviour for a selected function in a given phase
	function automatic lpc_pin_t pin_rule(input lpc_func_t fn,
		input lpc_phase_t ph, input logic lvl);
		lpc_pin_t r;
		r = '{act: ACT_HIZ, in_en: 1'b0, pull: 1'b0, analog: 1'b0,
			wakeup: 1'b0};
		if (fn == FN_ANALOG) begin
			r.analog = 1'b1;
		end else begin
			unique case (ph)
				PH_POR: r.act = ACT_HIZ;
				PH_EXTRST, PH_INTRST: begin
					if (fn == FN_JTAG) begin
						r.pull = 1'b1;
						r.in_en = 1'b1;
					end
				end
				PH_RUN: begin
					r.act = ACT_LIVE;
					r.in_en = 1'b1;
				end
				PH_STBY: begin
					// Interrupt-capable pins stay live so events are caught
					if (!lvl || fn == FN_JTAG || fn == FN_EXTINT ||
						fn == FN_NMI || fn == FN_DEEP_STANDBY_WAKEUP_IN || fn == FN_TRACE ||
						fn == FN_CEC) begin
						r.act = ACT_KEEP;
						r.in_en = 1'b1;
					end
				end
				PH_DEEP: begin
					if (fn == FN_JTAG || fn == FN_CEC) begin
						r.act = ACT_KEEP;
						r.in_en = 1'b1;
					end else if (fn == FN_DEEP_STANDBY_WAKEUP_IN || fn == FN_NMI) begin
						r.wakeup = 1'b1;
					end else if (!lvl) begin
						r.act = ACT_PORT;
					end
				end
				PH_RETURN: begin
					if (fn == FN_JTAG || fn == FN_CEC) begin
						r.act = ACT_KEEP;
						r.in_en = 1'b1;
					end else begin
						r.act = ACT_PORT;
					end
				end
				default: r.act = ACT_HIZ;
			endcase
		end
		return r;
	endfunction : pin_rule

	// Phase decode; supply and reset states take priority over modes
	always_comb begin
		if (por_sync[1]) begin
			phase = PH_POR;
		end else if (!xrst_sync[1]) begin
			phase = PH_EXTRST;
		end else if (int_reset_i) begin
			phase = PH_INTRST;
		end else if (ret_flag) begin
			phase = PH_RETURN;
		end else begin
			unique case (mode_i)
				MD_RUN, MD_SLEEP: phase = PH_RUN;
				MD_MAIN_TIMER, MD_SUB_TIMER, MD_LCR_TIMER, MD_RTC,
				MD_STOP: phase = PH_STBY;
				MD_DS_RTC, MD_DS_STOP: phase = PH_DEEP;
				MD_DS_RETURN: phase = PH_RETURN;
				default: phase = PH_RUN;
			endcase
		end
	end

	assign wr_en = psel_i && penable_i && pready && pwrite_i;
	assign rd_en = psel_i && penable_i && !pready && !pwrite_i;

	// Register file, APB answer and held port values
	always_comb begin
		next_spl = standby_pin_level;
		next_func = func;
		next_port_data = port_data;
		next_port_dir = port_dir;
		next_ret_flag = ret_flag;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		// One wait state: pready rises one cycle into the access phase
		next_pready = psel_i && penable_i && !pready;
		if (psel_i && penable_i && !pready) begin
			unique case (paddr_i)
				ADDR_CTRL, ADDR_FUNC0, ADDR_FUNC1, ADDR_PORT,
				ADDR_STATUS, ADDR_PADIN: next_pslverr = 1'b0;
				default: next_pslverr = 1'b1;
			endcase
		end
		if (rd_en) begin
			next_prdata = 32'h0;
			unique case (paddr_i)
				ADDR_CTRL: next_prdata[CTRL_SPL_BIT] = standby_pin_level;
				ADDR_FUNC0: next_prdata = func[31:0];
				ADDR_FUNC1: next_prdata = func[63:32];
				ADDR_PORT: next_prdata = {port_dir, port_data};
				ADDR_STATUS: begin
					next_prdata[STAT_PHASE_LSB +: 3] = phase;
					next_prdata[STAT_RETURN_BIT] = ret_flag;
					next_prdata[STAT_MAIN_OSC_BIT] = main_run;
					next_prdata[STAT_SUB_OSC_BIT] = sub_run;
				end
				ADDR_PADIN: next_prdata[NPIN-1:0] = pad_in;
				default: next_prdata = 32'h0;
			endcase
		end
		if (wr_en) begin
			unique case (paddr_i)
				ADDR_CTRL: begin
					next_spl = pwdata_i[CTRL_SPL_BIT];
					if (pwdata_i[CTRL_RELEASE_BIT]) begin
						next_ret_flag = 1'b0;
					end
				end
				ADDR_FUNC0: next_func[31:0] = pwdata_i;
				ADDR_FUNC1: next_func[63:32] = pwdata_i;
				ADDR_PORT: begin
					next_port_data = pwdata_i[NPIN-1:0];
					next_port_dir = pwdata_i[PORT_DIR_LSB +: NPIN];
				end
				default: next_spl = standby_pin_level;
			endcase
		end
		// Return state is set by hardware; set wins over the release write
		if (mode_i == MD_DS_RETURN) begin
			next_ret_flag = 1'b1;
		end
		// Port values freeze on leaving run so standby holds the last ones
		next_held_data = held_data;
		next_held_dir = held_dir;
		if (phase == PH_RUN) begin
			next_held_data = port_data;
			next_held_dir = port_dir;
		end
	end

	// Pad drive, pull, input gating and oscillator enables
	always_comb begin
		lpc_pin_t r;
		lpc_func_t fn;
		r = '{act: ACT_HIZ, in_en: 1'b0, pull: 1'b0, analog: 1'b0,
			wakeup: 1'b0};
		fn = FN_GPIO;
		next_pads = '0;
		for (int i = 0; i < NPIN; i++) begin
			fn = lpc_func_t'(func[i*FN_W +: FN_W]);
			r = pin_rule(fn, phase, standby_pin_level);
			next_pads.oe_n[i] = 1'b1;
			next_pads.out[i] = 1'b0;
			unique case (r.act)
				ACT_HIZ: next_pads.oe_n[i] = 1'b1;
				ACT_LIVE, ACT_KEEP: begin
					if (fn == FN_GPIO) begin
						// Live in run, frozen copy in standby
						next_pads.out[i] = (r.act == ACT_LIVE) ?
							port_data[i] : held_data[i];
						next_pads.oe_n[i] = (r.act == ACT_LIVE) ?
							!port_dir[i] : !held_dir[i];
					end else begin
						next_pads.out[i] = periph_out_i[i];
						next_pads.oe_n[i] = !periph_oe_i[i];
					end
				end
				ACT_PORT: begin
					next_pads.out[i] = held_data[i];
					next_pads.oe_n[i] = !held_dir[i];
				end
			endcase
			next_pads.pull[i] = r.pull;
			next_pads.in_en[i] = r.in_en;
			next_pads.analog[i] = r.analog;
			next_pads.wakeup[i] = r.wakeup;
		end
		// Forced-low internal input; wakeup path still sees the pad
		next_pad_in = pad_s2 & (pads.in_en | pads.wakeup);
		next_main_run = !(mode_i == MD_SUB_TIMER || mode_i == MD_LCR_TIMER ||
			mode_i == MD_RTC || mode_i == MD_STOP || mode_i == MD_DS_RTC ||
			mode_i == MD_DS_STOP);
		next_sub_run = !(mode_i == MD_STOP ||
			mode_i == MD_DS_STOP);
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_sync <= 2'b11;
			xrst_sync <= 2'b00;
			pad_s1 <= '0;
			pad_s2 <= '0;
			standby_pin_level <= CTRL_SPL_RST;
			func <= FUNC_RST;
			port_data <= PORT_DATA_RST;
			port_dir <= PORT_DIR_RST;
			held_data <= PORT_DATA_RST;
			held_dir <= PORT_DIR_RST;
			ret_flag <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pads <= '{out: '0, oe_n: '1, pull: '0, in_en: '0,
				analog: '0, wakeup: '0};
			pad_in <= '0;
			main_run <= 1'b1;
			sub_run <= 1'b1;
		end else begin
			por_sync <= {por_sync[0], por_i};
			xrst_sync <= {xrst_sync[0], external_reset_n_i};
			pad_s1 <= pad_i;
			pad_s2 <= pad_s1;
			standby_pin_level <= next_spl;
			func <= next_func;
			port_data <= next_port_data;
			port_dir <= next_port_dir;
			held_data <= next_held_data;
			held_dir <= next_held_dir;
			ret_flag <= next_ret_flag;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			pads <= next_pads;
			pad_in <= next_pad_in;
			main_run <= next_main_run;
			sub_run <= next_sub_run;
		end
	end

	assign prdata_o = prdata;
	assign pready_o = pready;
	assign pslverr_o = pslverr;
	assign pads_o = pads;
	assign pad_in_o = pad_in;
	assign main_osc_run_o = main_run;
	assign sub_osc_run_o = sub_run;

endmodule : lpc_pin_state

// File: test/lpc_pin_state_checker.sv
// Port assertions for the low-power pin state controller.
// Assumes the return flag is released before low-power modes.
`timescale 1ns/1ps
module lpc_chk
	import lpc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic por_i,
	input wire logic external_reset_n_i,
	input wire logic int_reset_i,
	input wire lpc_mode_t mode_i,
	input wire logic [NPIN-1:0] pad_in_o,
	input wire lpc_pads_t pads_o,
	input wire logic main_osc_run_o,
	input wire logic sub_osc_run_o
);
	logic [2:0] quiet;
	logic [2:0] next_quiet;
	logic ok;
	// Synchronisers need a few edges before the phase follows mode_i
	always_comb begin
		next_quiet = quiet;
		if (por_i || !external_reset_n_i || int_reset_i)
			next_quiet = 3'h0;
		else if (quiet != 3'h4)
			next_quiet = quiet + 3'h1;
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			quiet <= 3'h0;
		else
			quiet <= next_quiet;
	end
	assign ok = quiet == 3'h4;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	property p_analog;
		((pads_o.analog & ~pads_o.oe_n) | (pads_o.analog & pads_o.in_en))
			== 16'h0;
	endproperty
	a_analog: assert property (p_analog)
		else $error("analog pin active");
	property p_gate;
		(pad_in_o & ~$past(pads_o.in_en | pads_o.wakeup)) == 16'h0;
	endproperty
	a_gate: assert property (p_gate)
		else $error("input not forced");
	property p_por;
		por_i [*3] |=> &pads_o.oe_n;
	endproperty
	a_por: assert property (p_por)
		else $error("pin driven in por");
	property p_ext;
		!external_reset_n_i [*3] |=> (&pads_o.oe_n) &&
			((pads_o.pull & ~pads_o.in_en) == 16'h0);
	endproperty
	a_ext: assert property (p_ext)
		else $error("bad reset pins");
	property p_apb;
		psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_apb: assert property (p_apb) else $error("bad ready timing");
	property p_main_off;
		ok && ($past(mode_i) inside {MD_SUB_TIMER, MD_LCR_TIMER, MD_RTC,
			MD_STOP, MD_DS_RTC, MD_DS_STOP}) |-> !main_osc_run_o;
	endproperty
	a_main_off: assert property (p_main_off)
		else $error("main osc on");
	property p_main_on;
		ok && ($past(mode_i) inside {MD_RUN, MD_SLEEP, MD_MAIN_TIMER})
			|-> main_osc_run_o;
	endproperty
	a_main_on: assert property (p_main_on)
		else $error("main osc off");
	property p_sub;
		ok |-> sub_osc_run_o == !($past(mode_i) inside {MD_STOP, MD_DS_STOP});
	endproperty
	a_sub: assert property (p_sub)
		else $error("sub osc wrong");
	property p_wake;
		ok && ($past(mode_i) inside {MD_DS_RTC, MD_DS_STOP}) |->
			(pads_o.wakeup & ~pads_o.oe_n) == 16'h0;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wakeup pin driven");
endmodule : lpc_chk

// File: test/tb.sv
// Self-checking bench for the low-power pin state controller.
// Assumes lpc_pkg and the design are compiled first.
`timescale 1ns/1ps
module tb;
	import lpc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, e;
	logic por = 1'b0;
	logic ext_n = 1'b1;
	logic irst = 1'b0;
	lpc_mode_t mode = MD_RUN;
	logic [15:0] pout = 16'h0;
	logic [15:0] poe = 16'h0;
	logic [15:0] pad = 16'h0;
	logic [15:0] dat, dir;
	logic [15:0] xo, xi, pad_in;
	logic [1:0] xq;
	// Pins 0..3 carry analog, JTAG, wakeup and interrupt functions
	localparam logic [15:0] M = 16'hfff0;
	lpc_pads_t pads;
	int err_total = 0;
	int checked = 0;
	int seed = 32'h012b;
	lpc_pin_state dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .por_i(por),
		.external_reset_n_i(ext_n), .int_reset_i(irst), .mode_i(mode),
		.periph_out_i(pout), .periph_oe_i(poe), .pad_in_o(pad_in),
		.pad_i(pad), .pads_o(pads), .main_osc_run_o(), .sub_osc_run_o());
	always #10 clk_sys_i = ~clk_sys_i;
	task automatic end_sim;
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] s, x);
		checked++;
		if (s !== x) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1);
		chk("apb_wait", n, 32'd2);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic go(input lpc_mode_t m);
		@(posedge clk_sys_i);
		mode <= m;
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask : go
	// Floating when the level bit applies, else the run drive is kept
	function automatic logic [15:0] exp_oe(lpc_mode_t m, logic standby_pin_level);
		if (standby_pin_level && m inside {[MD_MAIN_TIMER:MD_DS_STOP]})
			return 16'hffff;
		return ~dir;
	endfunction : exp_oe
	initial begin
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'h0);
		apb(1'b0, 12'hffc, 32'h0);
		chk("unmapped", {rd[0], e}, 2'b01);
		apb(1'b1, ADDR_FUNC0, 32'h0000_5632);
		for (int i = 0; i < 4; i++) begin
			dat = 16'($random(seed));
			dir = (i == 0) ? 16'hffff : 16'($random(seed));
			pout <= 16'($random(seed));
			poe <= 16'($random(seed));
			pad <= 16'($random(seed));
			apb(1'b1, ADDR_PORT, {dir, dat});
			for (int s = 0; s < 2; s++) begin
				apb(1'b1, ADDR_CTRL, 32'(s));
				for (int m = 0; m < 9; m++) begin
					go(lpc_mode_t'(m));
					xo = exp_oe(lpc_mode_t'(m), s[0]);
					xi = (m > 6 || (s == 1 && m > 1)) ? 16'h0 : M;
					xq = (m < 7) ? {pout[3], !poe[3]} :
						(s == 1) ? 2'b01 : {dat[3], !dir[3]};
					chk("oe", pads.oe_n & M, xo & M);
					chk("out", pads.out & ~xo & M, dat & ~xo & M);
					chk("in", pads.in_en & M, xi);
					chk("pin", pad_in & M, pad & xi);
					chk("ana", {pads.analog[0], pads.oe_n[0], pads.in_en[0],
						pad_in[0]}, 4'b1100);
					chk("jtg", {pads.out[1], pads.oe_n[1]},
						{pout[1], !poe[1]});
					chk("irq", {pads.out[3], pads.oe_n[3]}, xq);
					if (m > 6)
						chk("wake", {pads.wakeup[2], pads.oe_n[2]},
							2'b11);
					go(MD_RUN);
				end
			end
		end
		go(MD_DS_RETURN);
		go(MD_RUN);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("ret", rd[STAT_RETURN_BIT], 1'b1);
		chk("ret_in", pads.in_en & M, 16'h0);
		apb(1'b1, ADDR_CTRL, 32'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("rel", rd[STAT_RETURN_BIT], 1'b0);
		ext_n <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		#1;
		chk("jtag", {pads.pull[1], pads.in_en[1], pads.oe_n}, 18'h3ffff);
		@(posedge clk_sys_i);
		ext_n <= 1'b1;
		irst <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1;
		chk("irst", {pads.pull[1], pads.in_en[1]}, 2'b11);
		@(posedge clk_sys_i);
		irst <= 1'b0;
		por <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1;
		chk("por", pads.oe_n, 16'hffff);
		@(posedge clk_sys_i);
		por <= 1'b0;
		end_sim();
	end
	initial begin
		#1000000;
		err_total++;
		end_sim();
	end
endmodule : tb

bind lpc_pin_state lpc_chk u_chk (.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .por_i(por_i),
	.external_reset_n_i(external_reset_n_i), .int_reset_i(int_reset_i),
	.mode_i(mode_i), .pad_in_o(pad_in_o), .pads_o(pads_o),
	.main_osc_run_o(main_osc_run_o), .sub_osc_run_o(sub_osc_run_o));
